// >>> src/guard_host_pkg.sv
// Constants and carriers for the protected-flash host controller.
// Assumes one 125 MHz clock; the flash bus pins are driven from flip-flops.
package guard_host_pkg;
   // ---------------------------------------------------------------
   // Command port register map (host side)
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h1;
   localparam logic [3:0] REG_WDATA = 4'h2;
   localparam logic [3:0] REG_RDATA = 4'h3;
   localparam logic [3:0] REG_STATUS = 4'h4;
   // Command codes written to REG_CTRL
   localparam logic [3:0] OP_READ = 4'h1;
   localparam logic [3:0] OP_PROGRAM = 4'h2;
   localparam logic [3:0] OP_ERASE = 4'h3;
   localparam logic [3:0] OP_ENTER_REGION = 4'h4;
   localparam logic [3:0] OP_EXIT_REGION = 4'h5;
   // Status bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_IN_REGION = 1;
   localparam int ST_REFUSED = 2;
   localparam int ST_LOCKOUT = 3;
   localparam int ST_TOP_BIT = 4;
   // ---------------------------------------------------------------
   // Flash command sequence constants
   // ---------------------------------------------------------------
   localparam logic [21:0] UNLOCK_ADDR1 = 22'h000555;
   localparam logic [21:0] UNLOCK_ADDR2 = 22'h0002aa;
   localparam logic [15:0] UNLOCK_DATA1 = 16'h00aa;
   localparam logic [15:0] UNLOCK_DATA2 = 16'h0055;
   localparam logic [15:0] CMD_PROGRAM = 16'h00a0;
   localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
   localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;
   localparam logic [15:0] CMD_ENTER_REGION = 16'h0088;
   localparam logic [15:0] CMD_EXIT_REGION = 16'h0090;
   localparam logic [15:0] CMD_EXIT_FINAL = 16'h0000;
   localparam int TOP_DATA_BIT = 7;
   // Boot sector indexes held by the write-guard pin
   localparam logic [7:0] FIRST_BOOT_SECTOR = 8'h00;
   localparam logic [7:0] SECOND_BOOT_SECTOR = 8'h01;
   localparam logic [7:0] PENULT_BOOT_SECTOR = 8'h8c;
   localparam logic [7:0] LAST_BOOT_SECTOR = 8'h8d;
   localparam int REGION_BYTES = 256;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int WE_LOW_NS = 40;
   localparam int WE_LOW_CYC = (WE_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int RD_ACCESS_NS = 80;
   localparam int RD_ACCESS_CYC = (RD_ACCESS_NS * CLK_MHZ + 999) / 1000;
   // Flash bus pin group
   typedef struct packed {
      logic cs_n;
      logic oe_n;
      logic we_n;
      logic [21:0] addr;
      logic [15:0] dq;
      logic dq_oe;
   } flash_bus_t;
   typedef struct packed {
      logic [21:0] addr;
      logic [15:0] data;
   } bus_cycle_t;
endpackage

// >>> src/flash_cycle_engine.sv
// One write or read cycle on the flash bus pins.
// Assumes the caller holds the request until done pulses.
`timescale 1ns/1ns
module flash_cycle_engine
   import guard_host_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Request
   input wire logic start_in,
   input wire logic is_write_in,
   input wire bus_cycle_t cyc_in,
   output logic done_out,
   output logic [15:0] rdata_out,
   // Pins
   output flash_bus_t bus_out,
   input wire logic [15:0] dq_in
);
   typedef enum logic [1:0] {E_IDLE, E_ACT, E_END} eng_t;
   eng_t st_q, st_d;
   logic [7:0] cnt_q, cnt_d;
   flash_bus_t bus_q, bus_d;
   logic [15:0] rd_q, rd_d;
   logic done_q, done_d;

   // ---------------------------------------------------------------
   // Cycle sequencing
   // ---------------------------------------------------------------
   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q;
      bus_d = bus_q;
      rd_d = rd_q;
      done_d = 1'b0;
      case (st_q)
         E_IDLE:
         begin
            if (start_in && !done_q)
            begin
               // Write: chip select and write strobe low with output enable high
               bus_d.cs_n = 1'b0;
               bus_d.oe_n = is_write_in;
               bus_d.we_n = !is_write_in;
               bus_d.addr = cyc_in.addr;
               bus_d.dq = cyc_in.data;
               bus_d.dq_oe = is_write_in;
               cnt_d = is_write_in ? 8'(WE_LOW_CYC) : 8'(RD_ACCESS_CYC);
               st_d = E_ACT;
            end
         end
         E_ACT:
         begin
            if (cnt_q > 8'h01)
            begin
               cnt_d = cnt_q - 8'h01;
            end
            else
            begin
               rd_d = dq_in;
               // Strobe rising edge commits the cycle
               bus_d.we_n = 1'b1;
               bus_d.oe_n = 1'b1;
               st_d = E_END;
            end
         end
         default:
         begin
            bus_d.cs_n = 1'b1;
            bus_d.dq_oe = 1'b0;
            done_d = 1'b1;
            st_d = E_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_q <= E_IDLE;
         cnt_q <= 8'h00;
         bus_q <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 22'h0, dq: 16'h0,
                    dq_oe: 1'b0};
         rd_q <= 16'h0000;
         done_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         bus_q <= bus_d;
         rd_q <= rd_d;
         done_q <= done_d;
      end
   end

   assign done_out = done_q;
   assign rdata_out = rd_q;
   assign bus_out = bus_q;

   chk_write_not_read: assert property (@(posedge clk) disable iff (!nrst)
      !bus_q.we_n |-> (!bus_q.cs_n && bus_q.oe_n))
      else $error("write strobe low without chip select or with output enable");
endmodule

// >>> src/flash_guard_host.sv
// Host controller for a NOR flash with boot-sector write guard and a secured region.
// Assumes software drives the command port; flash pins sampled on CLK_IN.
`timescale 1ns/1ns
module flash_guard_host
   import guard_host_pkg::*;
(
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   // Command port
   input wire logic [3:0] ADDR_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [31:0] RDATA_OUT,
   // Flash pins
   output logic FL_CS_N_OUT,
   output logic FL_OE_N_OUT,
   output logic FL_WE_N_OUT,
   output logic [21:0] FL_ADDR_OUT,
   output logic [15:0] FL_DQ_OUT,
   output logic FL_DQ_OE_OUT,
   input wire logic [15:0] FL_DQ_IN,
   output logic FL_GUARD_N_OUT,
   // Board status
   input wire logic SUPPLY_OK_IN
);
   typedef enum logic [2:0] {S_IDLE, S_SEQ, S_WAIT, S_DONE} seq_t;
   seq_t st_q, st_d;
   logic [2:0] step_q, step_d;
   logic [2:0] len_q, len_d;
   logic [3:0] op_q, op_d;
   logic [21:0] addr_q, addr_d;
   logic [15:0] wdata_q, wdata_d;
   logic [15:0] rdata_q, rdata_d;
   logic in_region_q, in_region_d;
   logic refused_q, refused_d;
   logic guard_q, guard_d;
   logic [31:0] rdo_q, rdo_d;
   logic start;
   logic is_write;
   logic done;
   bus_cycle_t cyc;
   flash_bus_t bus;
   logic [15:0] eng_rdata;

   // Boot sector test on the sector index (upper address bits)
   function automatic logic is_boot(input logic [21:0] a);
      logic [7:0] s;
      s = a[21:14];
      is_boot = (s == FIRST_BOOT_SECTOR) || (s == SECOND_BOOT_SECTOR) ||
                (s == PENULT_BOOT_SECTOR) || (s == LAST_BOOT_SECTOR);
   endfunction

   // Cycle of the current sequence step
   function automatic bus_cycle_t step_cycle(input logic [3:0] op, input logic [2:0] k,
                                             input logic [21:0] a, input logic [15:0] d);
      bus_cycle_t c;
      c = '{addr: a, data: d};
      case (k)
         3'h0: c = '{addr: UNLOCK_ADDR1, data: UNLOCK_DATA1};
         3'h1: c = '{addr: UNLOCK_ADDR2, data: UNLOCK_DATA2};
         3'h2:
         begin
            c.addr = UNLOCK_ADDR1;
            if (op == OP_PROGRAM) c.data = CMD_PROGRAM;
            else if (op == OP_ERASE) c.data = CMD_ERASE_SETUP;
            else if (op == OP_ENTER_REGION) c.data = CMD_ENTER_REGION;
            else c.data = CMD_EXIT_REGION;
         end
         3'h3:
         begin
            if (op == OP_ERASE) c = '{addr: UNLOCK_ADDR1, data: UNLOCK_DATA1};
            else if (op == OP_EXIT_REGION) c = '{addr: 22'h0, data: CMD_EXIT_FINAL};
         end
         3'h4: c = '{addr: UNLOCK_ADDR2, data: UNLOCK_DATA2};
         default: c = '{addr: a, data: CMD_SECTOR_ERASE};
      endcase
      step_cycle = c;
   endfunction

   // ---------------------------------------------------------------
   // Command sequencer
   // ---------------------------------------------------------------
   always_comb
   begin
      st_d = st_q;
      step_d = step_q;
      len_d = len_q;
      op_d = op_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      in_region_d = in_region_q;
      refused_d = refused_q;
      guard_d = guard_q;
      rdo_d = 32'h0;
      start = 1'b0;
      is_write = 1'b1;
      cyc = step_cycle(op_q, step_q, addr_q, wdata_q);
      if (WR_IN && ADDR_IN == REG_ADDR) addr_d = WDATA_IN[21:0];
      if (WR_IN && ADDR_IN == REG_WDATA) wdata_d = WDATA_IN[15:0];
      case (st_q)
         S_IDLE:
         begin
            if (WR_IN && ADDR_IN == REG_CTRL)
            begin
               guard_d = WDATA_IN[8];
               op_d = WDATA_IN[3:0];
               step_d = 3'h0;
               refused_d = 1'b0;
               // Main array outside the boot sectors is neither read nor written while mapped to the region
               if (in_region_q && (WDATA_IN[3:0] == OP_READ || WDATA_IN[3:0] == OP_PROGRAM ||
                   WDATA_IN[3:0] == OP_ERASE) && !is_boot(addr_q))
                  refused_d = 1'b1;
               else if (WDATA_IN[3:0] == OP_READ)
               begin
                  len_d = 3'h0;
                  step_d = 3'h6;
                  st_d = S_SEQ;
               end
               // Commands other than OP_READ only issued above supply lockout; reads go ahead in lockout
               else if (!SUPPLY_OK_IN)
                  refused_d = 1'b1;
               else if (WDATA_IN[3:0] >= OP_PROGRAM && WDATA_IN[3:0] <= OP_EXIT_REGION)
               begin
                  // Unlock cycles lead every sequence
                  if (WDATA_IN[3:0] == OP_ERASE) len_d = 3'h5;
                  else if (WDATA_IN[3:0] == OP_ENTER_REGION) len_d = 3'h2;
                  else len_d = 3'h3;
                  st_d = S_SEQ;
               end
               else
                  refused_d = 1'b1;
            end
         end
         S_SEQ:
         begin
            start = 1'b1;
            is_write = (op_q != OP_READ);
            if (step_q == 3'h6) cyc = '{addr: addr_q, data: 16'h0};
            if (op_q == OP_PROGRAM && step_q == 3'h3) cyc = '{addr: addr_q, data: wdata_q};
            if (done)
            begin
               if (op_q == OP_READ) rdata_d = eng_rdata;
               if (step_q == len_q || step_q == 3'h6) st_d = S_DONE;
               else step_d = step_q + 3'h1;
            end
         end
         default:
         begin
            // Region mapping follows the enter and exit sequences
            if (op_q == OP_ENTER_REGION) in_region_d = 1'b1;
            if (op_q == OP_EXIT_REGION) in_region_d = 1'b0;
            st_d = S_IDLE;
         end
      endcase
      if (RD_IN)
      begin
         if (ADDR_IN == REG_RDATA) rdo_d = {16'h0, rdata_q};
         else if (ADDR_IN == REG_ADDR) rdo_d = {10'h0, addr_q};
         else if (ADDR_IN == REG_STATUS)
         begin
            rdo_d[ST_BUSY] = (st_q != S_IDLE);
            rdo_d[ST_IN_REGION] = in_region_q;
            rdo_d[ST_REFUSED] = refused_q;
            rdo_d[ST_LOCKOUT] = !SUPPLY_OK_IN;
            rdo_d[ST_TOP_BIT] = rdata_q[TOP_DATA_BIT];
         end
         else rdo_d = 32'h0;
      end
   end

   always_ff @(posedge CLK_IN or negedge NRST_IN)
   begin
      if (!NRST_IN)
      begin
         st_q <= S_IDLE;
         step_q <= 3'h0;
         len_q <= 3'h0;
         op_q <= 4'h0;
         addr_q <= 22'h0;
         wdata_q <= 16'h0;
         rdata_q <= 16'h0;
         in_region_q <= 1'b0;
         refused_q <= 1'b0;
         guard_q <= 1'b1;
         rdo_q <= 32'h0;
      end
      else
      begin
         st_q <= st_d;
         step_q <= step_d;
         len_q <= len_d;
         op_q <= op_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         in_region_q <= in_region_d;
         refused_q <= refused_d;
         guard_q <= guard_d;
         rdo_q <= rdo_d;
      end
   end

   flash_cycle_engine u_eng (
      .clk(CLK_IN),
      .nrst(NRST_IN),
      .start_in(start),
      .is_write_in(is_write),
      .cyc_in(cyc),
      .done_out(done),
      .rdata_out(eng_rdata),
      .bus_out(bus),
      .dq_in(FL_DQ_IN)
   );

   assign RDATA_OUT = rdo_q;
   assign FL_CS_N_OUT = bus.cs_n;
   assign FL_OE_N_OUT = bus.oe_n;
   assign FL_WE_N_OUT = bus.we_n;
   assign FL_ADDR_OUT = bus.addr;
   assign FL_DQ_OUT = bus.dq;
   assign FL_DQ_OE_OUT = bus.dq_oe;
   // Guard pin low locks boot sectors; high leaves stored state
   assign FL_GUARD_N_OUT = guard_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_lockout_no_seq: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      (st_q == S_IDLE && WR_IN && ADDR_IN == REG_CTRL && !SUPPLY_OK_IN &&
       WDATA_IN[3:0] != OP_READ) |=> st_q == S_IDLE)
      else $error("sequence started below supply lockout");
   chk_unlock_first: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      (st_q == S_SEQ && op_q != OP_READ && step_q == 3'h0) |->
      cyc.data == UNLOCK_DATA1)
      else $error("sequence without unlock cycle");
   chk_region_exit: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      (st_q == S_DONE && op_q == OP_EXIT_REGION) |=> !in_region_q)
      else $error("region mapping kept after exit");
   chk_region_enter: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      (st_q == S_DONE && op_q == OP_ENTER_REGION) |=> in_region_q)
      else $error("region mapping missing after enter");
   chk_main_blocked: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      (st_q == S_IDLE && in_region_q && WR_IN && ADDR_IN == REG_CTRL &&
       WDATA_IN[3:0] == OP_PROGRAM && !is_boot(addr_q)) |=> refused_q)
      else $error("main array access while in region");
   chk_read_delay: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      RD_IN && ADDR_IN == REG_ADDR |=> RDATA_OUT == {10'h0, $past(addr_q)})
      else $error("read data not one cycle later");
   chk_guard_ctrl: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      (st_q == S_IDLE && WR_IN && ADDR_IN == REG_CTRL) |=>
      FL_GUARD_N_OUT == $past(WDATA_IN[8]))
      else $error("guard pin not following control");
   chk_strobe_rule: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
      !FL_WE_N_OUT |-> (!FL_CS_N_OUT && FL_OE_N_OUT && FL_DQ_OE_OUT))
      else $error("illegal write cycle levels");
   cov_program: cover property (@(posedge CLK_IN) st_q == S_DONE && op_q == OP_PROGRAM);
   cov_erase: cover property (@(posedge CLK_IN) st_q == S_DONE && op_q == OP_ERASE);
   cov_enter: cover property (@(posedge CLK_IN) in_region_q);
   cov_refuse: cover property (@(posedge CLK_IN) refused_q);
endmodule

// >>> test/flash_dev_model.sv
// Behavioural flash device on the far side of the host controller.
// Assumes registered host pins; write cycles latch on the strobe rising edge.
`timescale 1ns/1ns
module flash_dev_model
   import guard_host_pkg::*;
#(
   parameter bit FACTORY_LOCKED = 1'b1,
   parameter logic [255:0] PROT_INIT = '0
)
(
   // Pins
   input wire logic nrst_in,
   input wire logic supply_ok_in,
   input wire logic cs_n_in,
   input wire logic oe_n_in,
   input wire logic we_n_in,
   input wire logic guard_n_in,
   input wire logic clear_elevated_in,
   input wire logic [21:0] addr_in,
   input wire logic [15:0] dq_in,
   output logic [15:0] dq_out
);
   logic [15:0] mem [logic [21:0]];
   logic [255:0] prot_q = PROT_INIT;
   logic region_q = 1'b0;
   logic [2:0] step_q = 3'd0;
   logic [15:0] rval;
   logic [7:0] sec;

   assign sec = addr_in[21:14];

   function automatic logic locked(input logic [7:0] s);
      logic boot;
      boot = (s == FIRST_BOOT_SECTOR) || (s == SECOND_BOOT_SECTOR) ||
             (s == PENULT_BOOT_SECTOR) || (s == LAST_BOOT_SECTOR);
      // Elevated clear lifts stored protection only; guard low still holds boot sectors
      return (boot && !guard_n_in) || (prot_q[s] && !clear_elevated_in);
   endfunction

   // Region words in sector 0: 0x5a, then FACTORY_LOCKED, then address bits 6:0
   always_comb
   begin
      if (region_q && sec == FIRST_BOOT_SECTOR)
         rval = {8'h5a, FACTORY_LOCKED, addr_in[6:0]};
      else
         rval = mem.exists(addr_in) ? mem[addr_in] : 16'hffff;
   end

   // Released bus shows the inverse, never a stale value
   assign dq_out = (!cs_n_in && !oe_n_in) ? rval : ~rval;

   always @(posedge we_n_in or negedge nrst_in or negedge supply_ok_in)
   begin
      if (!nrst_in || !supply_ok_in)
      begin
         step_q <= 3'd0;
         if (!nrst_in)
            region_q <= 1'b0;
      end
      else if (!cs_n_in && oe_n_in)
      begin
         case (step_q)
            3'd0: step_q <= (addr_in == UNLOCK_ADDR1 && dq_in == UNLOCK_DATA1) ? 3'd1 : 3'd0;
            3'd1: step_q <= (addr_in == UNLOCK_ADDR2 && dq_in == UNLOCK_DATA2) ? 3'd2 : 3'd0;
            3'd2:
            begin
               if (dq_in == CMD_ENTER_REGION)
                  region_q <= 1'b1;
               step_q <= (dq_in == CMD_PROGRAM) ? 3'd3 : (dq_in == CMD_ERASE_SETUP) ? 3'd4 :
                         (dq_in == CMD_EXIT_REGION) ? 3'd7 : 3'd0;
            end
            3'd3:
            begin
               if (!locked(sec) && !(region_q && FACTORY_LOCKED))
                  mem[addr_in] = rval & dq_in;
               step_q <= 3'd0;
            end
            3'd4: step_q <= (dq_in == UNLOCK_DATA1) ? 3'd5 : 3'd0;
            3'd5: step_q <= (dq_in == UNLOCK_DATA2) ? 3'd6 : 3'd0;
            3'd6:
            begin
               if (dq_in == CMD_SECTOR_ERASE && !locked(sec))
                  mem.delete(addr_in);
               step_q <= 3'd0;
            end
            default:
            begin
               if (dq_in == CMD_EXIT_FINAL)
                  region_q <= 1'b0;
               step_q <= 3'd0;
            end
         endcase
      end
   end
endmodule

// >>> test/flash_guard_host_tb.sv
// Self-checking bench for the flash host controller.
// Assumes a factory-locked device model on the flash pins.
`timescale 1ns/1ns
module flash_guard_host_tb import guard_host_pkg::*;;
   logic CLK_IN, NRST_IN, WR_IN, RD_IN, SUPPLY_OK_IN;
   logic [3:0] ADDR_IN;
   logic [31:0] WDATA_IN, RDATA_OUT;
   logic FL_CS_N_OUT, FL_OE_N_OUT, FL_WE_N_OUT, FL_DQ_OE_OUT, FL_GUARD_N_OUT;
   logic [21:0] FL_ADDR_OUT;
   logic [15:0] FL_DQ_OUT, FL_DQ_IN, model_dq;
   logic clear_elevated;
   int num_errors = 0;
   int n_checks = 0;
   int cs_cycles = 0;
   logic [31:0] st, v;
   logic [7:0] boot [4] = '{8'h00, 8'h01, 8'h8c, 8'h8d};

   assign FL_DQ_IN = FL_DQ_OE_OUT ? FL_DQ_OUT : model_dq;

   flash_guard_host flash_guard_host_i (.CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .ADDR_IN(ADDR_IN),
      .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
      .FL_CS_N_OUT(FL_CS_N_OUT), .FL_OE_N_OUT(FL_OE_N_OUT), .FL_WE_N_OUT(FL_WE_N_OUT),
      .FL_ADDR_OUT(FL_ADDR_OUT), .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE_OUT(FL_DQ_OE_OUT),
      .FL_DQ_IN(FL_DQ_IN), .FL_GUARD_N_OUT(FL_GUARD_N_OUT), .SUPPLY_OK_IN(SUPPLY_OK_IN));

   flash_dev_model #(.FACTORY_LOCKED(1'b1), .PROT_INIT(256'h1_0000_0000)) flash_dev_model_i (
      .nrst_in(NRST_IN),
      .supply_ok_in(SUPPLY_OK_IN), .cs_n_in(FL_CS_N_OUT), .oe_n_in(FL_OE_N_OUT),
      .we_n_in(FL_WE_N_OUT), .guard_n_in(FL_GUARD_N_OUT),
      .clear_elevated_in(clear_elevated), .addr_in(FL_ADDR_OUT),
      .dq_in(FL_DQ_OUT), .dq_out(model_dq));

   initial
   begin
      CLK_IN = 1'b0;
      forever #4 CLK_IN = ~CLK_IN;
   end

   // Pin watch: strobe only inside a selected write
   always @(posedge CLK_IN)
   begin
      if (!FL_CS_N_OUT)
         cs_cycles++;
      if (NRST_IN && !FL_WE_N_OUT && (FL_CS_N_OUT || !FL_OE_N_OUT))
      begin
         num_errors++;
         $display("ERROR %0t write strobe outside a selected write", $time);
      end
   end

   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge CLK_IN);
      ADDR_IN <= a;
      WDATA_IN <= d;
      WR_IN <= 1'b1;
      @(posedge CLK_IN);
      WR_IN <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge CLK_IN);
      ADDR_IN <= a;
      RD_IN <= 1'b1;
      @(posedge CLK_IN);
      RD_IN <= 1'b0;
      #1 d = RDATA_OUT;
   endtask

   // Issue one flash operation and poll until it leaves busy
   task automatic op(input logic [3:0] code, input logic [21:0] a, input logic [15:0] d,
                     input logic guard, output logic [31:0] s);
      int n;
      n = 0;
      s = 32'h1;
      wr(REG_ADDR, {10'h000, a});
      wr(REG_WDATA, {16'h0000, d});
      wr(REG_CTRL, {23'h000000, guard, 4'h0, code});
      while (s[ST_BUSY] !== 1'b0 && n < 300)
      begin
         rd(REG_STATUS, s);
         n++;
      end
      if (s[ST_BUSY] !== 1'b0)
      begin
         num_errors++;
         $display("ERROR %0t operation never finished", $time);
         close_out();
      end
   endtask

   task automatic rdf(input logic [21:0] a, input logic guard, output logic [31:0] d);
      op(OP_READ, a, 16'h0000, guard, st);
      rd(REG_RDATA, d);
   endtask

   task automatic s_reset();
      chk({FL_CS_N_OUT, FL_OE_N_OUT, FL_WE_N_OUT, FL_DQ_OE_OUT, FL_GUARD_N_OUT}, 32'h1d, "idle");
      rd(REG_STATUS, v);
      chk(v, 32'h0, "status after reset");
   endtask

   task automatic s_program();
      op(OP_PROGRAM, 22'h010004, 16'h12b4, 1'b1, st);
      chk(st[ST_REFUSED], 1'b0, "program refused");
      rdf(22'h010004, 1'b1, v);
      chk(v[15:0], 16'h12b4, "program data");
      chk(st[ST_TOP_BIT], 1'b1, "top bit of read");
      @(posedge CLK_IN);
      #1 chk(RDATA_OUT, 32'h0, "read data held too long");
      op(OP_ERASE, 22'h010004, 16'h0000, 1'b1, st);
      rdf(22'h010004, 1'b1, v);
      chk(v[15:0], 16'hffff, "erase data");
   endtask

   task automatic s_guard();
      foreach (boot[i])
      begin
         op(OP_PROGRAM, {boot[i], 14'h0010}, 16'h0f0f, 1'b0, st);
         chk(FL_GUARD_N_OUT, 1'b0, "guard pin level");
         rdf({boot[i], 14'h0010}, 1'b0, v);
         chk(v[15:0], 16'hffff, "boot sector written under guard");
      end
      op(OP_PROGRAM, 22'h234010, 16'h0f0f, 1'b1, st);
      rdf(22'h234010, 1'b1, v);
      chk(v[15:0], 16'h0f0f, "boot sector with guard released");
   endtask

   // Sector 0x20 is stored as protected in the model
   task automatic s_temp();
      op(OP_PROGRAM, 22'h080010, 16'h3c3c, 1'b1, st);
      rdf(22'h080010, 1'b1, v);
      chk(v[15:0], 16'hffff, "stored protection ignored");
      @(posedge CLK_IN);
      clear_elevated <= 1'b1;
      op(OP_PROGRAM, 22'h080010, 16'h3c3c, 1'b1, st);
      op(OP_PROGRAM, 22'h000020, 16'h3c3c, 1'b0, st);
      rdf(22'h080010, 1'b0, v);
      chk(v[15:0], 16'h3c3c, "temporary unprotect");
      rdf(22'h000020, 1'b0, v);
      chk(v[15:0], 16'hffff, "boot sector under guard in unprotect");
      @(posedge CLK_IN);
      clear_elevated <= 1'b0;
      op(OP_PROGRAM, 22'h080010, 16'h0000, 1'b1, st);
      rdf(22'h080010, 1'b1, v);
      chk(v[15:0], 16'h3c3c, "protection not restored");
   endtask

   task automatic s_supply();
      int n;
      @(posedge CLK_IN);
      SUPPLY_OK_IN <= 1'b0;
      n = cs_cycles;
      op(OP_PROGRAM, 22'h010020, 16'h0000, 1'b1, st);
      chk({st[ST_LOCKOUT], st[ST_REFUSED]}, 2'b11, "lockout refusal");
      chk(cs_cycles, n, "pin activity in lockout");
      @(posedge CLK_IN);
      SUPPLY_OK_IN <= 1'b1;
   endtask

   task automatic s_region();
      op(OP_ENTER_REGION, 22'h0, 16'h0, 1'b1, st);
      chk(st[ST_IN_REGION], 1'b1, "region entry");
      rdf(22'h000003, 1'b1, v);
      chk(st[ST_TOP_BIT], 1'b1, "factory indicator");
      op(OP_PROGRAM, 22'h010008, 16'h0000, 1'b1, st);
      chk(st[ST_REFUSED], 1'b1, "main array program in region");
      op(OP_READ, 22'h010008, 16'h0000, 1'b1, st);
      chk(st[ST_REFUSED], 1'b1, "main array read in region");
      op(OP_PROGRAM, 22'h000003, 16'h0000, 1'b1, st);
      rdf(22'h000003, 1'b1, v);
      chk(v[15:0], 16'h5a83, "locked region modified");
      op(OP_EXIT_REGION, 22'h0, 16'h0, 1'b1, st);
      chk(st[ST_IN_REGION], 1'b0, "region exit");
      rdf(22'h000003, 1'b1, v);
      chk(v[15:0], 16'hffff, "array after exit");
      op(4'h7, 22'h0, 16'h0, 1'b1, st);
      chk(st[ST_REFUSED], 1'b1, "unknown operation");
   endtask

   task automatic s_rst_region();
      op(OP_ENTER_REGION, 22'h0, 16'h0, 1'b1, st);
      @(posedge CLK_IN);
      NRST_IN <= 1'b0;
      repeat (4) @(posedge CLK_IN);
      NRST_IN <= 1'b1;
      rd(REG_STATUS, v);
      chk(v[ST_IN_REGION], 1'b0, "region after reset");
   endtask

   initial
   begin
      NRST_IN = 1'b1;
      ADDR_IN = 4'h0;
      WDATA_IN = 32'h0;
      WR_IN = 1'b0;
      RD_IN = 1'b0;
      SUPPLY_OK_IN = 1'b1;
      clear_elevated = 1'b0;
      // A falling edge after time zero, so every reset process sees it
      #1;
      NRST_IN = 1'b0;
      repeat (4) @(posedge CLK_IN);
      NRST_IN <= 1'b1;
      s_reset();
      s_program();
      s_guard();
      s_temp();
      s_supply();
      s_region();
      s_rst_region();
      close_out();
   end
endmodule
